// *** sim/host_bus.sv ***
module host_bus (
  input wire clk_in,
  input wire [7:0] base_in,
  input wire [7:0] rdata_in,
  input wire oe_n_in,
  output logic [9:0] addr_out = 10'h000,
  output logic ior_n_out = 1'b1,
  output logic iow_n_out = 1'b1,
  output logic [7:0] wdata_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte cycles only, one strobe at a time, setup and recovery
  task automatic io_wr(input logic [1:0] ofs, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = {base_in, ofs};
    wdata_out = d;
    repeat (3) @(negedge clk_in);
    iow_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    iow_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    // a released bus must not keep showing the old byte
    wdata_out = ~d;
  endtask
  task automatic io_rd(input logic [1:0] ofs, output logic [7:0] d,
                       output logic ok);
    d = 8'h00;
    ok = 1'b0;
    @(negedge clk_in);
    addr_out = {base_in, ofs};
    repeat (3) @(negedge clk_in);
    ior_n_out = 1'b0;
    // sample on the falling edge, where the registered drive has settled
    for (int i = 0; i < 10 && !ok; i++) begin
      @(negedge clk_in);
      if (oe_n_in === 1'b0) begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
    @(negedge clk_in);
    ior_n_out = 1'b1;
    for (int i = 0; i < 10 && oe_n_in !== 1'b1; i++)
      @(negedge clk_in);
    repeat (4) @(negedge clk_in);
  endtask
endmodule

// *** sim/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sw = 8'h40;
  logic [7:0] hb = 8'h40;
  logic [4:0] src = 5'h00;
  logic [7:0] ip = 8'hC3;
  wire [9:0] addr;
  wire ior_n;
  wire iow_n;
  wire oe_n;
  wire fout;
  wire [7:0] wd;
  wire [7:0] rdat;
  wire [7:0] pb;
  wire [4:0] co;
  wire [4:0] arm;
  logic [7:0] rd;
  logic ok;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer cycles = 0;
  always #2 clk = ~clk;
  timer_cmd_port i_timer_cmd_port (
    .CLK_SYS_IN(clk),
    .SRST_IN(srst),
    .ADDR_IN(addr),
    .IOR_N_IN(ior_n),
    .IOW_N_IN(iow_n),
    .DATA_IN(wd),
    .BASE_SW_IN(sw),
    .INPUT_PORT_BITS_IN(ip),
    .SOURCE_IN(src),
    .DATA_OUT(rdat),
    .DATA_OE_N_OUT(oe_n),
    .OUTPUT_PORT_BITS_OUT(pb),
    .COUNTER_OUT_OUT(co),
    .ARMED_OUT(arm),
    .FOUT_GATE_OFF_OUT(fout)
  );
  host_bus i_host_bus (
    .clk_in(clk),
    .base_in(hb),
    .rdata_in(rdat),
    .oe_n_in(oe_n),
    .addr_out(addr),
    .ior_n_out(ior_n),
    .iow_n_out(iow_n),
    .wdata_out(wd)
  );
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] o, input logic [7:0] d);
    i_host_bus.io_wr(o, d);
  endtask
  task automatic rdc(input logic [1:0] o, input logic [7:0] e);
    i_host_bus.io_rd(o, rd, ok);
    check({7'h0, ok}, 8'h01);
    check(rd, e);
  endtask
  // multi-byte moves through the data port, low byte first
  task automatic wrn(input int n, input logic [31:0] d);
    for (int k = 0; k < n; k++)
      wr(2'h0, d[8*k +: 8]);
  endtask
  task automatic rdn(input int n, input logic [31:0] e);
    for (int k = 0; k < n; k++)
      rdc(2'h0, e[8*k +: 8]);
  endtask
  task automatic refused(input logic [1:0] o);
    i_host_bus.io_rd(o, rd, ok);
    check({7'h0, ok}, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      $display("ERROR %0t run did not finish", $time);
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check({2'h0, oe_n, arm | co}, 8'h20);
    wr(2'h1, 8'h17);
    wrn(2, 32'h0000);
    wr(2'h1, 8'h01);
    rdc(2'h1, 8'h01);
    wr(2'h0, 8'h5A);
    rdc(2'h1, 8'h00);
    wrn(3, 32'h00BEEFA5);
    wr(2'h1, 8'h01);
    rdn(4, 32'hBEEFA55A);
    wr(2'h1, 8'hE8);
    wr(2'h1, 8'h01);
    rdn(4, 32'hA55AA55A);
    wr(2'h1, 8'hEE);
    wr(2'h1, 8'hEF);
    wr(2'h1, 8'h17);
    rdn(1, 32'h00);
    rdc(2'h1, 8'h01);
    wr(2'h1, 8'hE7);
    wr(2'h1, 8'h17);
    rdn(2, 32'h5000);
    check({7'h0, fout}, 8'h01);
    wr(2'h1, 8'hE6);
    wr(2'h1, 8'hE0);
    check({7'h0, fout}, 8'h00);
    wr(2'h1, 8'h07);
    wrn(4, 32'h44332211);
    wr(2'h1, 8'h07);
    rdn(4, 32'h44332211);
    wr(2'h1, 8'h1F);
    rdn(1, 32'h01);
    wr(2'h1, 8'h0A);
    wrn(2, 32'h1234);
    wr(2'h1, 8'h42);
    wr(2'h1, 8'h22);
    check({3'h0, arm}, 8'h02);
    repeat (3) begin
      src = 5'h02;
      repeat (4) @(negedge clk);
      src = 5'h00;
      repeat (4) @(negedge clk);
    end
    wr(2'h1, 8'h82);
    check({3'h0, arm}, 8'h00);
    wr(2'h1, 8'h12);
    rdn(2, 32'h1231);
    wr(2'h1, 8'hF2);
    wr(2'h1, 8'hA2);
    wr(2'h1, 8'h12);
    rdn(2, 32'h1230);
    wr(2'h1, 8'h63);
    check({3'h0, arm}, 8'h03);
    wr(2'h1, 8'hA1);
    check({3'h0, arm}, 8'h03);
    wr(2'h1, 8'h11);
    rdn(2, 32'hBEEF);
    wr(2'h1, 8'hC3);
    check({3'h0, arm}, 8'h00);
    // hold-inc keeps element 3 and walks from hold 1 to hold 2
    wr(2'h1, 8'h19);
    rdn(4, 32'h1230BEEF);
    for (int i = 1; i <= 5; i++) begin
      wr(2'h1, 8'hE8 | i[7:0]);
      check({3'h0, co}, (8'h01 << i) - 8'h01);
    end
    rdc(2'h1, 8'h3F);
    for (int i = 1; i <= 5; i++) begin
      wr(2'h1, 8'hE0 | i[7:0]);
      check({3'h0, co}, (8'h1F << i) & 8'h1F);
    end
    wr(2'h1, 8'hED);
    wr(2'h1, 8'h23);
    wr(2'h1, 8'hFF);
    check({3'h0, arm | co}, 8'h00);
    rdc(2'h1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(2'h1, i ? 8'h06 : 8'h00);
      rdc(2'h0, 8'h00);
      rdc(2'h1, 8'h01);
    end
    rdc(2'h2, 8'hC3);
    ip = 8'h3C;
    rdc(2'h2, 8'h3C);
    wr(2'h3, 8'h96);
    check(pb, 8'h96);
    refused(2'h3);
    hb = 8'h41;
    refused(2'h1);
    sw = 8'hFF;
    hb = 8'hFF;
    rdc(2'h1, 8'h01);
    sw = 8'h3F;
    hb = 8'h3F;
    refused(2'h1);
    tally_and_finish;
  end
endmodule

// *** sim/timer_cmd_port_props.sv ***
module timer_cmd_port_props #(
  parameter NCNT = 5
) (
  input wire CLK_SYS_IN,
  input wire SRST_IN,
  input wire [9:0] ADDR_IN,
  input wire IOR_N_IN,
  input wire IOW_N_IN,
  input wire [7:0] DATA_IN,
  input wire [7:0] BASE_SW_IN,
  input wire [7:0] INPUT_PORT_BITS_IN,
  input wire [7:0] DATA_OUT,
  input wire DATA_OE_N_OUT,
  input wire [7:0] OUTPUT_PORT_BITS_OUT,
  input wire [4:0] COUNTER_OUT_OUT,
  input wire [4:0] ARMED_OUT,
  input wire FOUT_GATE_OFF_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  // ----
  // decode seen from the pins; bases below the window never match
  // ----
  wire base_ok = BASE_SW_IN >= 8'h40;
  wire at_cmd = base_ok && ADDR_IN == {BASE_SW_IN, 2'h1};
  wire at_out = base_ok && ADDR_IN == {BASE_SW_IN, 2'h3};
  sequence cmd_s(logic [7:0] c);
    $fell(IOW_N_IN) && at_cmd && DATA_IN == c;
  endsequence
  // the host holds its write byte well past these windows, so the
  // consequents read it live instead of through local variables
  property sel_p(logic [2:0] op, logic on);
    $fell(IOW_N_IN) && at_cmd && DATA_IN[7:5] == op
      |-> ##[2:6] (ARMED_OUT & DATA_IN[4:0]) ==
          (on ? DATA_IN[4:0] : 5'h00);
  endproperty
  property out_p;
    $fell(IOW_N_IN) && at_out
      |-> ##[1:5] OUTPUT_PORT_BITS_OUT == DATA_IN;
  endproperty
  oe_delay_a: assert property (
    $fell(DATA_OE_N_OUT) |-> !$past(IOR_N_IN, 3) && !$past(IOR_N_IN, 2))
    else $error("read drive began too early");
  oe_hold_a: assert property (
    !DATA_OE_N_OUT && !IOR_N_IN |=> !DATA_OE_N_OUT)
    else $error("read drive dropped while strobe low");
  oe_release_a: assert property (
    $rose(IOR_N_IN) |-> ##[1:6] DATA_OE_N_OUT)
    else $error("read drive not released");
  base_match_a: assert property (
    $fell(DATA_OE_N_OUT) |-> $past(BASE_SW_IN, 3) >= 8'h40
      && $past(ADDR_IN[9:2], 3) == $past(BASE_SW_IN, 3)
      && $past(ADDR_IN[1:0], 3) != 2'h3)
    else $error("read answered outside the window");
  din_read_a: assert property (
    $fell(DATA_OE_N_OUT) && $past(ADDR_IN[1:0], 3) == 2'h2
      |-> DATA_OUT == $past(INPUT_PORT_BITS_IN, 3))
    else $error("input port read wrong");
  dout_write_a: assert property (out_p)
    else $error("output port not written");
  arm_sel_a: assert property (sel_p(3'h1, 1'b1))
    else $error("selected counters not armed");
  disarm_sel_a: assert property (sel_p(3'h6, 1'b0))
    else $error("selected counters not disarmed");
  gate_off_a: assert property (
    cmd_s(8'hEE) |-> ##[2:6] FOUT_GATE_OFF_OUT)
    else $error("gate off bit not set");
  gate_on_a: assert property (
    cmd_s(8'hE6) |-> ##[2:6] !FOUT_GATE_OFF_OUT)
    else $error("gate off bit not cleared");
  master_reset_a: assert property (
    cmd_s(8'hFF) |-> ##[2:6] (ARMED_OUT | COUNTER_OUT_OUT) == 5'h00)
    else $error("master reset left counter state");
  cover property (cmd_s(8'hFF));
  cover property ($fell(DATA_OE_N_OUT));
  cover property ($rose(ARMED_OUT[1]));
endmodule

bind timer_cmd_port timer_cmd_port_props #(.NCNT(NCNT)) i_props (
  .CLK_SYS_IN(CLK_SYS_IN),
  .SRST_IN(SRST_IN),
  .ADDR_IN(ADDR_IN),
  .IOR_N_IN(IOR_N_IN),
  .IOW_N_IN(IOW_N_IN),
  .DATA_IN(DATA_IN),
  .BASE_SW_IN(BASE_SW_IN),
  .INPUT_PORT_BITS_IN(INPUT_PORT_BITS_IN),
  .DATA_OUT(DATA_OUT),
  .DATA_OE_N_OUT(DATA_OE_N_OUT),
  .OUTPUT_PORT_BITS_OUT(OUTPUT_PORT_BITS_OUT),
  .COUNTER_OUT_OUT(COUNTER_OUT_OUT),
  .ARMED_OUT(ARMED_OUT),
  .FOUT_GATE_OFF_OUT(FOUT_GATE_OFF_OUT)
);

// *** verilog/count_cell.v ***
module count_cell #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst,
  input wire load_cmd,
  input wire arm_cmd,
  input wire disarm_cmd,
  input wire save_cmd,
  input wire step_cmd,
  input wire tick,
  input wire wr_load_lo,
  input wire wr_load_hi,
  input wire wr_hold_lo,
  input wire wr_hold_hi,
  input wire [7:0] wdata,
  output reg [WIDTH-1:0] load_val,
  output reg [WIDTH-1:0] hold_val,
  output reg armed
);

  reg [WIDTH-1:0] count;
  wire advance = step_cmd | (armed & tick);

  always @(posedge clk) begin
    if (rst) begin
      load_val <= {WIDTH{1'b0}};
      hold_val <= {WIDTH{1'b0}};
      count <= {WIDTH{1'b0}};
      armed <= 1'b0;
    end else begin
      if (wr_load_lo) begin
        load_val[7:0] <= wdata;
      end
      if (wr_load_hi) begin
        load_val[15:8] <= wdata;
      end
      // a save snapshots the count seen before this edge's change
      if (save_cmd) begin
        hold_val <= count;
      end else begin
        if (wr_hold_lo) begin
          hold_val[7:0] <= wdata;
        end
        if (wr_hold_hi) begin
          hold_val[15:8] <= wdata;
        end
      end
      if (load_cmd) begin
        count <= load_val;
      end else if (advance) begin
        // terminal count reloads from load_val, so the cell sticks at zero only when load_val is zero
        if (count == {WIDTH{1'b0}}) begin
          count <= load_val;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
      if (disarm_cmd) begin
        armed <= 1'b0;
      end else if (arm_cmd) begin
        armed <= 1'b1;
      end
    end
  end

endmodule

// *** verilog/timer_cmd_port.v ***
// Function
// - four ports: data, command/status, input, output
// - base 100..3FC, four-byte aligned
// - 000 command loads element and group
// - 001 arms selected counters
// - 010 loads selected counters from reload
// - 011 loads and arms selected counters
// - 100 disarms and saves into hold
// - 101 saves only; 110 disarms only
// - low five bits select counters one-five
// - 11100N clears counter N output bit
// - 11101N sets counter N output bit
// - master codes set/clear three mode bits
// - group 1..5 counters, 7 control, others illegal
// - control elements: alarm1, alarm2, master, status
// - pointer load sets byte toggle to one
// - 8-bit mode inverts toggle per byte
// - toggle readable in status, pointer not
// - 16-bit registers move low byte first
// - element or group auto-advances unless sequencing inhibited
`include "timer_port_regs.vh"

module timer_cmd_port #(
  parameter NCNT = 5
) (
  input wire CLK_SYS_IN,
  input wire SRST_IN,
  input wire [9:0] ADDR_IN,
  input wire IOR_N_IN,
  input wire IOW_N_IN,
  input wire [7:0] DATA_IN,
  input wire [7:0] BASE_SW_IN,
  input wire [7:0] INPUT_PORT_BITS_IN,
  input wire [4:0] SOURCE_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE_N_OUT,
  output reg [7:0] OUTPUT_PORT_BITS_OUT,
  output reg [4:0] COUNTER_OUT_OUT,
  output reg [4:0] ARMED_OUT,
  output reg FOUT_GATE_OFF_OUT
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg ior_s1, ior_s2, ior_prev;
  reg iow_s1, iow_s2, iow_prev;
  reg [9:0] addr_s1, addr_s2;
  reg [7:0] din_s1, din_s2;
  reg [7:0] sw_s1, sw_s2;
  reg [7:0] ip_s1, ip_s2;
  reg [4:0] src_s1, src_s2, src_prev;

  always @(posedge CLK_SYS_IN) begin
    ior_s1 <= IOR_N_IN;
    ior_s2 <= ior_s1;
    iow_s1 <= IOW_N_IN;
    iow_s2 <= iow_s1;
    addr_s1 <= ADDR_IN;
    addr_s2 <= addr_s1;
    din_s1 <= DATA_IN;
    din_s2 <= din_s1;
    sw_s1 <= BASE_SW_IN;
    sw_s2 <= sw_s1;
    ip_s1 <= INPUT_PORT_BITS_IN;
    ip_s2 <= ip_s1;
    src_s1 <= SOURCE_IN;
    src_s2 <= src_s1;
  end

  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ior_prev <= 1'b1;
      iow_prev <= 1'b1;
      src_prev <= 5'h00;
    end else begin
      ior_prev <= ior_s2;
      iow_prev <= iow_s2;
      src_prev <= src_s2;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // switches carry base bits 9:2, so alignment is built in
  wire [9:0] base = {sw_s2, 2'b00};
  wire base_ok = (base >= `BASE_MIN) && (base <= `BASE_MAX);
  wire hit = base_ok && (addr_s2[9:2] == sw_s2);
  wire [1:0] ofs = addr_s2[1:0];
  wire wr_take = hit & iow_prev & ~iow_s2;
  wire rd_start = hit & ior_prev & ~ior_s2;
  wire [4:0] ticks = src_s2 & ~src_prev;

  // ----------------------------------------------------------------
  // pointer, master mode and counter state
  // ----------------------------------------------------------------
  reg [1:0] element;
  reg [2:0] group;
  reg byte_toggle;
  reg [15:0] master_mode;
  reg rd_active;
  reg rd_data_port;

  wire seq_inhibit = master_mode[`MM_SEQ_INHIBIT];
  wire bus_width = master_mode[`MM_BUS_WIDTH];

  wire [7:0] cmd = din_s2;
  wire [2:0] opcode = cmd[7:5];
  wire [4:0] sel = cmd[4:0];
  wire [2:0] num = cmd[2:0];
  wire cmd_take = wr_take & (ofs == `OFS_CMD);
  wire master_reset = cmd_take & (cmd == `CMD_MASTER_RESET);
  wire num_ok = (num >= `GRP_FIRST) && (num <= `GRP_LAST);
  wire [4:0] num_hot = num_ok ? (5'h01 << (num - 3'h1)) : 5'h00;
  wire single = cmd_take & (opcode == `OP_SINGLE) & ~master_reset;

  // per-counter command pulses, one select bit per counter; step decodes the counter number instead
  wire [4:0] sel_now = cmd_take ? sel : 5'h00;
  wire [4:0] c_arm = ((opcode == `OP_ARM) |
                      (opcode == `OP_LOAD_ARM)) ? sel_now : 5'h00;
  wire [4:0] c_load = ((opcode == `OP_LOAD) |
                       (opcode == `OP_LOAD_ARM)) ? sel_now : 5'h00;
  wire [4:0] c_disarm = ((opcode == `OP_DISARM_SAVE) |
                         (opcode == `OP_DISARM)) ? sel_now : 5'h00;
  wire [4:0] c_save = ((opcode == `OP_DISARM_SAVE) |
                       (opcode == `OP_SAVE)) ? sel_now : 5'h00;
  wire [4:0] c_step = (single && cmd[4:3] == `SUB_STEP) ?
                      num_hot : 5'h00;

  // ----------------------------------------------------------------
  // data port targets
  // ----------------------------------------------------------------
  wire is_ctr = (group >= `GRP_FIRST) && (group <= `GRP_LAST);
  wire is_ctl = (group == `GRP_CONTROL);
  wire [2:0] cidx = group - 3'h1;
  wire [4:0] grp_hot = is_ctr ? (5'h01 << cidx) : 5'h00;
  wire data_wr = wr_take & (ofs == `OFS_DATA);
  wire lo_lane = data_wr & byte_toggle;
  wire hi_lane = data_wr & ~byte_toggle;
  wire on_load = is_ctr & (element == `EL_LOAD);
  wire on_hold = is_ctr & element[1];
  wire mem_sel = (is_ctr & (element == `EL_MODE)) |
                 (is_ctl & ~element[1]);
  wire [2:0] mem_addr = is_ctl ? (element[0] ? `MEM_ALARM2 : `MEM_ALARM1)
                               : cidx;
  wire [15:0] mem_rdata;

  word_store #(
    .DW(16),
    .AW(3),
    .DEPTH(`MEM_DEPTH)
  ) u_store (
    .clk(CLK_SYS_IN),
    .we_lo(lo_lane & mem_sel),
    .we_hi(hi_lane & mem_sel),
    .waddr(mem_addr),
    .wdata(din_s2),
    .raddr(mem_addr),
    .rdata(mem_rdata)
  );

  wire [16*NCNT-1:0] load_bus;
  wire [16*NCNT-1:0] hold_bus;
  wire [NCNT-1:0] armed_bus;
  wire cell_rst = SRST_IN | master_reset;

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cell
      count_cell #(
        .WIDTH(16)
      ) u_cell (
        .clk(CLK_SYS_IN),
        .rst(cell_rst),
        .load_cmd(c_load[gi]),
        .arm_cmd(c_arm[gi]),
        .disarm_cmd(c_disarm[gi]),
        .save_cmd(c_save[gi]),
        .step_cmd(c_step[gi]),
        .tick(ticks[gi]),
        .wr_load_lo(lo_lane & on_load & grp_hot[gi]),
        .wr_load_hi(hi_lane & on_load & grp_hot[gi]),
        .wr_hold_lo(lo_lane & on_hold & grp_hot[gi]),
        .wr_hold_hi(hi_lane & on_hold & grp_hot[gi]),
        .wdata(din_s2),
        .load_val(load_bus[16*gi +: 16]),
        .hold_val(hold_bus[16*gi +: 16]),
        .armed(armed_bus[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // pointer fields stay hidden; only the toggle shows
  wire [7:0] status = {2'b00, COUNTER_OUT_OUT, byte_toggle};
  reg [15:0] word;
  always @* begin
    word = 16'h0000;
    if (is_ctl) begin
      case (element)
        `EL_MASTER: word = master_mode;
        `EL_STATUS: word = {8'h00, status};
        default: word = mem_rdata;
      endcase
    end else if (is_ctr) begin
      case (element)
        `EL_MODE: word = mem_rdata;
        `EL_LOAD: word = load_bus[16*cidx +: 16];
        default: word = hold_bus[16*cidx +: 16];
      endcase
    end
  end

  reg [7:0] rd_byte;
  always @* begin
    case (ofs)
      `OFS_DATA: rd_byte = byte_toggle ? word[7:0] : word[15:8];
      `OFS_CMD: rd_byte = status;
      `OFS_DIN: rd_byte = ip_s2;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // pointer sequencing
  // ----------------------------------------------------------------
  wire rd_end = rd_active & ior_s2;
  wire xfer = data_wr | (rd_end & rd_data_port);
  // 16-bit mode holds the toggle and moves one byte per access, so every access completes
  wire word_done = bus_width | ~byte_toggle;
  wire [2:0] grp_next = (group == `GRP_LAST) ? `GRP_FIRST
                                             : group + 3'h1;

  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN || master_reset) begin
      element <= 2'h0;
      group <= 3'h0;
      byte_toggle <= 1'b1;
      master_mode <= `MM_RESET;
    end else if (cmd_take && opcode == `OP_POINTER) begin
      element <= cmd[4:3];
      group <= cmd[2:0];
      byte_toggle <= 1'b1;
    end else if (single) begin
      case (cmd)
        `CMD_SEQ_ON: master_mode[`MM_SEQ_INHIBIT] <= 1'b0;
        `CMD_SEQ_OFF: master_mode[`MM_SEQ_INHIBIT] <= 1'b1;
        `CMD_FOUT_ON: master_mode[`MM_FOUT_OFF] <= 1'b0;
        `CMD_FOUT_OFF: master_mode[`MM_FOUT_OFF] <= 1'b1;
        `CMD_BUS_8: master_mode[`MM_BUS_WIDTH] <= 1'b0;
        `CMD_BUS_16: master_mode[`MM_BUS_WIDTH] <= 1'b1;
        default: master_mode <= master_mode;
      endcase
    end else if (xfer && (is_ctr || is_ctl)) begin
      if (data_wr && is_ctl && element == `EL_MASTER) begin
        if (byte_toggle) begin
          master_mode[7:0] <= din_s2;
        end else begin
          master_mode[15:8] <= din_s2;
        end
      end
      if (!bus_width) begin
        byte_toggle <= ~byte_toggle;
      end
      if (word_done && !seq_inhibit) begin
        // hold-inc walks the hold registers across counters
        if (is_ctl) begin
          element <= (element == `EL_MASTER) ? `EL_ALARM1
                                             : element + 2'h1;
        end else if (element == `EL_HOLD_INC) begin
          group <= grp_next;
        end else if (element == `EL_HOLD) begin
          element <= `EL_MODE;
          group <= grp_next;
        end else begin
          element <= element + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // host-facing outputs
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rd_active <= 1'b0;
      rd_data_port <= 1'b0;
      DATA_OUT <= 8'h00;
      DATA_OE_N_OUT <= 1'b1;
      OUTPUT_PORT_BITS_OUT <= 8'h00;
      COUNTER_OUT_OUT <= 5'h00;
      ARMED_OUT <= 5'h00;
      FOUT_GATE_OFF_OUT <= 1'b0;
    end else begin
      ARMED_OUT <= armed_bus;
      FOUT_GATE_OFF_OUT <= master_mode[`MM_FOUT_OFF];
      if (rd_start && ofs != `OFS_DOUT) begin
        rd_active <= 1'b1;
        rd_data_port <= (ofs == `OFS_DATA);
        DATA_OUT <= rd_byte;
        DATA_OE_N_OUT <= 1'b0;
      end else if (rd_end) begin
        rd_active <= 1'b0;
        rd_data_port <= 1'b0;
        DATA_OE_N_OUT <= 1'b1;
      end
      if (wr_take && ofs == `OFS_DOUT) begin
        OUTPUT_PORT_BITS_OUT <= din_s2;
      end
      if (master_reset) begin
        COUNTER_OUT_OUT <= 5'h00;
      end else if (single && cmd[4:3] == `SUB_CLEAR) begin
        COUNTER_OUT_OUT <= COUNTER_OUT_OUT & ~num_hot;
      end else if (single && cmd[4:3] == `SUB_SET) begin
        COUNTER_OUT_OUT <= COUNTER_OUT_OUT | num_hot;
      end
    end
  end

endmodule

// *** verilog/timer_port_regs.vh ***
`ifndef TIMER_PORT_REGS_VH
`define TIMER_PORT_REGS_VH

// ----------------------------------------------------------------
// port offsets within the four-byte window
// ----------------------------------------------------------------
`define OFS_DATA 2'h0
`define OFS_CMD 2'h1
`define OFS_DIN 2'h2
`define OFS_DOUT 2'h3

// ----------------------------------------------------------------
// legal range of the switch-selected base address
// ----------------------------------------------------------------
`define BASE_MIN 10'h100
`define BASE_MAX 10'h3FC

// ----------------------------------------------------------------
// command opcodes (top three bits of the command byte)
// ----------------------------------------------------------------
`define OP_POINTER 3'h0
`define OP_ARM 3'h1
`define OP_LOAD 3'h2
`define OP_LOAD_ARM 3'h3
`define OP_DISARM_SAVE 3'h4
`define OP_SAVE 3'h5
`define OP_DISARM 3'h6
`define OP_SINGLE 3'h7

// sub-function in bits 4:3 of a single-bit command
`define SUB_CLEAR 2'h0
`define SUB_SET 2'h1
`define SUB_STEP 2'h2

// ----------------------------------------------------------------
// master control command codes
// ----------------------------------------------------------------
`define CMD_SEQ_ON 8'hE0
`define CMD_FOUT_ON 8'hE6
`define CMD_BUS_8 8'hE7
`define CMD_SEQ_OFF 8'hE8
`define CMD_FOUT_OFF 8'hEE
`define CMD_BUS_16 8'hEF
`define CMD_MASTER_RESET 8'hFF

// ----------------------------------------------------------------
// master mode register fields and reset value
// ----------------------------------------------------------------
`define MM_SEQ_INHIBIT 14
`define MM_BUS_WIDTH 13
`define MM_FOUT_OFF 12
`define MM_RESET 16'h0000

// ----------------------------------------------------------------
// pointer fields
// ----------------------------------------------------------------
`define GRP_FIRST 3'h1
`define GRP_LAST 3'h5
`define GRP_CONTROL 3'h7
`define EL_MODE 2'h0
`define EL_LOAD 2'h1
`define EL_HOLD 2'h2
`define EL_HOLD_INC 2'h3
`define EL_ALARM1 2'h0
`define EL_ALARM2 2'h1
`define EL_MASTER 2'h2
`define EL_STATUS 2'h3

// ----------------------------------------------------------------
// word store layout: five counter modes, then two alarms
// ----------------------------------------------------------------
`define MEM_ALARM1 3'h5
`define MEM_ALARM2 3'h6
`define MEM_DEPTH 7

`endif

// *** verilog/word_store.v ***
module word_store #(
  parameter DW = 16,
  parameter AW = 3,
  parameter DEPTH = 7
) (
  input wire clk,
  input wire we_lo,
  input wire we_hi,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we_lo) begin
      mem[waddr][7:0] <= wdata;
    end
    if (we_hi) begin
      mem[waddr][15:8] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
